// ===== amp_stage_model.sv
// Purpose: behavioural output amplifier stages seen by the control block
// Assumes: load condition commanded by the bench, one clock
// Notes: short sense follows the load only, never the driver controls
`default_nettype none

module amp_stage_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [1:0] loadShort,
  input wire logic [1:0] hpDriveOn,
  output logic [1:0] hpShort
);
  timeunit 1ns;
  timeprecision 1ns;
  // sense comparator, registered so the flag moves just after an edge
  // reported whatever the driver state, no control can hide it
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hpShort <= 2'h0;
    end else begin
      hpShort <= #1 loadShort;
    end
  end
endmodule : amp_stage_model

`default_nettype wire

// ===== output_driver_volume_control.sv
// Purpose: register bank and control logic for the analog output stage
// Assumes: register port and short inputs synchronous to core_clk
// Notes: register reads return one cycle after the address is presented
`default_nettype none

module output_driver_volume_control #(
  parameter int STEP_PERIOD = volume_ctl_pkg::STEP_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic swReset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  output logic [7:0] regRdData,
  input wire logic [1:0] softStepSel,
  input wire logic [1:0] hpShort,
  output logic [1:0] dacToVol,
  output logic [1:0] spkFeed,
  output logic [1:0] volMute,
  output logic [13:0] volAtten,
  output logic [1:0] hpDriveOn,
  output logic [1:0] hpCurrentLimit,
  output logic [7:0] hpGain,
  output logic [1:0] hpMute,
  output logic [1:0] commonModeSel,
  output logic lineoutMode
);
  import volume_ctl_pkg::*;

  // host-visible storage
  logic [1:0] hpPwr_q; // driver power bits, 0 left
  logic [1:0] cmSel_q; // common-mode level select
  logic sdMode_q; // 1 shutdown, 0 current limit
  logic fault_q; // read-only short flag
  logic [1:0] route_q; // dac to volume stage
  logic [7:0] spkVol_q [2]; // speaker volume registers
  logic [4:0] hpGainReg_q [2]; // gain and mute bits
  logic [1:0] drvCfg_q; // drive mode field

  // write strobes
  logic wrHpPwr;
  logic wrRoute;
  logic wrDrv;
  logic [1:0] wrSpk;
  logic [1:0] wrHpGain;

  // soft-step timing
  logic [15:0] stepCnt_q; // interval counter
  logic baseTick_q; // end of one interval
  logic halfDiv_q; // halves the rate for x2
  logic stepTick; // pulse to both steppers
  logic immediate; // stepping disabled

  // per-channel applied codes from the steppers
  logic [6:0] applied [2];

  // output flops
  logic [1:0] dacToVol_q;
  logic [1:0] spkFeed_q;
  logic [1:0] volMute_q;
  logic [13:0] volAtten_q;
  logic [1:0] hpDriveOn_q;
  logic [1:0] hpLimit_q;
  logic [7:0] hpGain_q;
  logic [1:0] hpMute_q;
  logic [1:0] cmOut_q;
  logic lineout_q;
  logic [7:0] regRdData_q;
  logic [7:0] rdMux_d;

  assign wrHpPwr = regWrEn && regAddr == HP_PWR_FAULT_OFS;
  assign wrRoute = regWrEn && regAddr == DAC_ROUTE_OFS;
  assign wrDrv = regWrEn && regAddr == HP_DRV_CFG_OFS;
  assign wrSpk[0] = regWrEn && regAddr == SPK_VOL_L_OFS;
  assign wrSpk[1] = regWrEn && regAddr == SPK_VOL_R_OFS;
  assign wrHpGain[0] = regWrEn && regAddr == HP_GAIN_L_OFS;
  assign wrHpGain[1] = regWrEn && regAddr == HP_GAIN_R_OFS;

  // driver power bits: a shutdown-mode short clears them
  // hardware clear wins, so a reset against a live short fails again
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hpPwr_q <= 2'h0;
    end else if (swReset) begin
      hpPwr_q <= 2'h0;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (sdMode_q && hpShort[ch]) begin
          hpPwr_q[ch] <= 1'b0;
        end else if (wrHpPwr) begin
          // power-stage reset keeps other settings
          hpPwr_q[ch] <= regWrData[ch == 0 ? HP_PWR_L_POS : HP_PWR_R_POS];
        end
      end
    end
  end

  // common-mode and short response mode
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmSel_q <= 2'h0;
      sdMode_q <= 1'b0;
    end else if (swReset) begin
      cmSel_q <= 2'h0;
      sdMode_q <= 1'b0;
    end else if (wrHpPwr) begin
      cmSel_q <= regWrData[HP_CM_LSB +: 2];
      sdMode_q <= regWrData[HP_SD_MODE_POS];
    end
  end

  // fault flag follows detection; detection has no enable
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= |hpShort;
    end
  end

  // routing and drive configuration
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      route_q <= 2'h0;
      drvCfg_q <= 2'h0;
    end else if (swReset) begin
      route_q <= 2'h0;
      drvCfg_q <= 2'h0;
    end else begin
      if (wrRoute) begin
        route_q <= {regWrData[ROUTE_R_POS], regWrData[ROUTE_L_POS]};
      end
      if (wrDrv) begin
        drvCfg_q <= regWrData[DRV_MODE_LSB +: 2];
      end
    end
  end

  // per-channel volume and gain registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int ch = 0; ch < 2; ch++) begin
        spkVol_q[ch] <= REG_RESET;
        hpGainReg_q[ch] <= 5'h00;
      end
    end else if (swReset) begin
      for (int ch = 0; ch < 2; ch++) begin
        spkVol_q[ch] <= REG_RESET;
        hpGainReg_q[ch] <= 5'h00;
      end
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (wrSpk[ch]) begin
          spkVol_q[ch] <= regWrData;
        end
        if (wrHpGain[ch]) begin
          hpGainReg_q[ch] <= regWrData[HP_MUTE_POS +: 5];
        end
      end
    end
  end

  // interval counter shared by both channels
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stepCnt_q <= 16'h0000;
      baseTick_q <= 1'b0;
    end else if (stepCnt_q == 16'(STEP_PERIOD - 1)) begin
      stepCnt_q <= 16'h0000;
      baseTick_q <= 1'b1;
    end else begin
      stepCnt_q <= stepCnt_q + 16'h0001;
      baseTick_q <= 1'b0;
    end
  end

  // divider for the slow stepping rate
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      halfDiv_q <= 1'b0;
    end else if (baseTick_q) begin
      halfDiv_q <= ~halfDiv_q;
    end
  end

  // the setting picks the interval or turns stepping off
  always_comb begin
    stepTick = 1'b0;
    immediate = 1'b0;
    unique case (step_sel_t'(softStepSel))
      STEP_X1: stepTick = baseTick_q;
      STEP_X2: stepTick = baseTick_q && halfDiv_q;
      STEP_OFF_A, STEP_OFF_B: immediate = 1'b1;
    endcase
  end

  // one stepper per speaker volume stage
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    vol_step_if stepBus ();
    assign stepBus.target = spkVol_q[ch][6:0];
    assign stepBus.stepTick = stepTick;
    assign stepBus.immediate = immediate;
    assign applied[ch] = stepBus.applied;
    vol_stepper u_step (
      .core_clk(core_clk),
      .rstn(rstn),
      .bus(stepBus)
    );
  end

  // analog-facing outputs, all registered
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dacToVol_q <= 2'h0;
      spkFeed_q <= 2'h0;
      volMute_q <= 2'h0;
      volAtten_q <= 14'h0000;
      hpGain_q <= 8'h00;
      hpMute_q <= 2'h0;
    end else begin
      dacToVol_q <= route_q;
      for (int ch = 0; ch < 2; ch++) begin
        spkFeed_q[ch] <= spkVol_q[ch][SPK_FEED_POS];
        // mute only with the feed bit clear and all-ones code
        volMute_q[ch] <= !spkVol_q[ch][SPK_FEED_POS]
          && spkVol_q[ch][6:0] == VOL_MUTE_CODE;
        // deepest codes share one attenuation step
        volAtten_q[ch*7 +: 7] <= (applied[ch] > VOL_FLOOR_CODE) ?
          VOL_FLOOR_CODE : applied[ch];
        hpGain_q[ch*4 +: 4] <= hpGainReg_q[ch][4:1];
        hpMute_q[ch] <= hpGainReg_q[ch][0];
      end
    end
  end

  // driver enables and short response
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hpDriveOn_q <= 2'h0;
      hpLimit_q <= 2'h0;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        // a short always takes the output off the load
        hpDriveOn_q[ch] <= hpPwr_q[ch] && !hpShort[ch];
        // limit mode keeps the bit set and clamps current
        hpLimit_q[ch] <= hpPwr_q[ch] && hpShort[ch] && !sdMode_q;
      end
    end
  end

  // global analog settings
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmOut_q <= 2'h0;
      lineout_q <= 1'b0;
    end else begin
      cmOut_q <= cmSel_q;
      lineout_q <= drvCfg_q == DRV_LINEOUT;
    end
  end

  // read multiplexer, unmapped addresses read zero
  always_comb begin
    rdMux_d = 8'h00;
    unique case (regAddr)
      HP_PWR_FAULT_OFS: begin
        rdMux_d[HP_PWR_L_POS] = hpPwr_q[0];
        rdMux_d[HP_PWR_R_POS] = hpPwr_q[1];
        rdMux_d[HP_CM_LSB +: 2] = cmSel_q;
        rdMux_d[HP_SD_MODE_POS] = sdMode_q;
        rdMux_d[HP_FAULT_POS] = fault_q;
      end
      DAC_ROUTE_OFS: begin
        rdMux_d[ROUTE_L_POS] = route_q[0];
        rdMux_d[ROUTE_R_POS] = route_q[1];
      end
      SPK_VOL_L_OFS: rdMux_d = spkVol_q[0];
      SPK_VOL_R_OFS: rdMux_d = spkVol_q[1];
      HP_GAIN_L_OFS: rdMux_d[HP_MUTE_POS +: 5] = hpGainReg_q[0];
      HP_GAIN_R_OFS: rdMux_d[HP_MUTE_POS +: 5] = hpGainReg_q[1];
      HP_DRV_CFG_OFS: rdMux_d[DRV_MODE_LSB +: 2] = drvCfg_q;
      default: rdMux_d = 8'h00;
    endcase
  end

  // registered read data
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      regRdData_q <= 8'h00;
    end else begin
      regRdData_q <= rdMux_d;
    end
  end

  assign regRdData = regRdData_q;
  assign dacToVol = dacToVol_q;
  assign spkFeed = spkFeed_q;
  assign volMute = volMute_q;
  assign volAtten = volAtten_q;
  assign hpDriveOn = hpDriveOn_q;
  assign hpCurrentLimit = hpLimit_q;
  assign hpGain = hpGain_q;
  assign hpMute = hpMute_q;
  assign commonModeSel = cmOut_q;
  assign lineoutMode = lineout_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // short while in shutdown mode: shut the driver
  sequence shortInSd(int ch);
    sdMode_q && hpShort[ch];
  endsequence

  shutdownClear_a: assert property (shortInSd(0) |=> !hpPwr_q[0] ##1 !hpDriveOn_q[0])
    else $error("left power bit survived a short in shutdown mode");

  restartRefail_a: assert property (
    (wrHpPwr && regWrData[HP_PWR_R_POS] && !swReset) ##1 shortInSd(1)
    |=> !hpPwr_q[1])
    else $error("right driver not shut again on a persisting short");

  faultFlag_a: assert property (hpShort[1] |=> fault_q && !hpDriveOn_q[1])
    else $error("short did not raise the flag and drop the output");

  currentLimit_a: assert property (
    (hpPwr_q[0] && hpShort[0] && !sdMode_q) |=> hpLimit_q[0] && hpPwr_q[0])
    else $error("current limit mode not applied");

  muteCode_a: assert property (
    (!spkVol_q[1][SPK_FEED_POS] && spkVol_q[1][6:0] == VOL_MUTE_CODE) |=> volMute_q[1])
    else $error("volume stage not muted on all-ones code");

  floorAtten_a: assert property (
    (applied[0] >= VOL_FLOOR_CODE) |=> volAtten_q[6:0] == VOL_FLOOR_CODE)
    else $error("deep code not held at floor attenuation");

  lineoutSel_a: assert property (
    (wrDrv && !swReset && regWrData[2:1] == DRV_LINEOUT) |=> ##1 lineout_q)
    else $error("lineout mode not entered");

  routeFeed_a: assert property (
    (wrSpk[0] && !swReset) |=> ##1 spkFeed_q[0] == $past(regWrData[SPK_FEED_POS], 2))
    else $error("speaker feed does not follow bit 7");

  routeDac_a: assert property (
    (wrRoute && !swReset) |=> ##1 dacToVol_q[1] == $past(regWrData[ROUTE_R_POS], 2))
    else $error("right dac routing does not follow bit 2");

  cmLevel_a: assert property ((wrHpPwr && !swReset) |=> ##1
    commonModeSel == $past(regWrData[4:3], 2))
    else $error("common-mode select does not follow write");

  gainMute_a: assert property ((wrHpGain[1] && !swReset) |=> ##1
    hpGain_q[7:4] == $past(regWrData[6:3], 2) && hpMute_q[1] == $past(regWrData[2], 2))
    else $error("right gain or mute does not follow write");
endmodule : output_driver_volume_control

`default_nettype wire

// ===== tb.sv
// Purpose: self-checking bench for the output driver volume control block
// Assumes: step interval shortened to 4 cycles, 25 MHz clock
// Notes: an array model of the registers predicts every read and output
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import volume_ctl_pkg::*;
  localparam int P = 4; // shortened step interval
  logic core_clk, rstn, swReset, regWrEn, lineoutMode;
  logic [7:0] regAddr, regWrData, regRdData, hpGain;
  logic [1:0] softStepSel, hpShort, loadShort, dacToVol, spkFeed, volMute;
  logic [1:0] hpDriveOn, hpCurrentLimit, hpMute, commonModeSel;
  logic [13:0] volAtten;
  int error_cnt = 0;
  int num_checks = 0;
  int seed = 73;
  logic [7:0] mr [0:255]; // model register file, unmapped stays 0
  logic [7:0] ofs [0:6] = '{HP_PWR_FAULT_OFS, DAC_ROUTE_OFS, SPK_VOL_L_OFS, SPK_VOL_R_OFS,
    HP_GAIN_L_OFS, HP_GAIN_R_OFS, HP_DRV_CFG_OFS};

  output_driver_volume_control #(.STEP_PERIOD(P)) uut (.core_clk(core_clk), .rstn(rstn),
    .swReset(swReset), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdData(regRdData), .softStepSel(softStepSel), .hpShort(hpShort),
    .dacToVol(dacToVol), .spkFeed(spkFeed), .volMute(volMute), .volAtten(volAtten),
    .hpDriveOn(hpDriveOn), .hpCurrentLimit(hpCurrentLimit), .hpGain(hpGain),
    .hpMute(hpMute), .commonModeSel(commonModeSel), .lineoutMode(lineoutMode));
  amp_stage_model amp (.core_clk(core_clk), .rstn(rstn), .loadShort(loadShort),
    .hpDriveOn(hpDriveOn), .hpShort(hpShort));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // writable bits per register, reserved bits read back 0 and the fault flag is set by upd
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      HP_PWR_FAULT_OFS: wmask = 8'hda;
      DAC_ROUTE_OFS: wmask = 8'h44;
      HP_GAIN_L_OFS, HP_GAIN_R_OFS: wmask = 8'h7c;
      HP_DRV_CFG_OFS: wmask = 8'h06;
      default: wmask = 8'hff;
    endcase
  endfunction : wmask

  function automatic logic [6:0] clampc(input logic [7:0] r);
    clampc = (r[6:0] > VOL_FLOOR_CODE) ? VOL_FLOOR_CODE : r[6:0];
  endfunction : clampc

  // live fault flag and shutdown clearing of power bits
  task automatic upd();
    mr[HP_PWR_FAULT_OFS][0] = |loadShort;
    if (mr[HP_PWR_FAULT_OFS][1]) begin
      mr[HP_PWR_FAULT_OFS][7:6] = mr[HP_PWR_FAULT_OFS][7:6] & ~{loadShort[0], loadShort[1]};
    end
  endtask : upd

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic chkOut(input string nm, input logic [13:0] exp, input logic [13:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chkOut

  task automatic chkReg(input logic [7:0] a, input logic [7:0] exp);
    num_checks++;
    if (regRdData !== exp) begin
      error_cnt++;
      $display("unexpected reg %h: expected %h seen %h", a, exp, regRdData);
    end
  endtask : chkReg

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    tick(1);
    regWrEn = 1'b0;
    mr[a] = d & wmask(a);
    upd();
  endtask : wr

  task automatic rd(input logic [7:0] a);
    tick(1);
    regAddr = a;
    tick(1);
    chkReg(a, mr[a]);
  endtask : rd

  task automatic outs();
    logic [7:0] h, l, r, g0, g1;
    logic [1:0] pw;
    h = mr[HP_PWR_FAULT_OFS];
    l = mr[SPK_VOL_L_OFS];
    r = mr[SPK_VOL_R_OFS];
    g0 = mr[HP_GAIN_L_OFS];
    g1 = mr[HP_GAIN_R_OFS];
    pw = {h[6], h[7]};
    chkOut("dacToVol", {mr[DAC_ROUTE_OFS][2], mr[DAC_ROUTE_OFS][6]}, dacToVol);
    chkOut("spkFeed", {r[7], l[7]}, spkFeed);
    chkOut("volMute", {!r[7] && r[6:0] == 7'h7f, !l[7] && l[6:0] == 7'h7f}, volMute);
    chkOut("volAtten", {clampc(r), clampc(l)}, volAtten);
    chkOut("hpDriveOn", pw & ~loadShort, hpDriveOn);
    chkOut("hpCurrentLimit", pw & loadShort & {2{~h[1]}}, hpCurrentLimit);
    chkOut("hpGain", {g1[6:3], g0[6:3]}, hpGain);
    chkOut("hpMute", {g1[2], g0[2]}, hpMute);
    chkOut("commonModeSel", h[4:3], commonModeSel);
    chkOut("lineoutMode", mr[HP_DRV_CFG_OFS][2:1] == 2'h3, lineoutMode);
  endtask : outs

  // watch the left applied code climb to a new target, one code at a time unless stepping is off
  task automatic stepRun(input logic [1:0] sel, input logic [6:0] t);
    int gap, n, seen;
    logic [6:0] prev;
    softStepSel = sel;
    wr(SPK_VOL_L_OFS, {1'b1, t});
    prev = volAtten[6:0];
    gap = 0;
    seen = 0;
    for (n = 0; n < 400 && volAtten[6:0] !== t; n++) begin
      tick(1);
      gap++;
      if (volAtten[6:0] !== prev) begin
        // stepping off: the first change must land on the target in one jump
        if (sel >= 2) chkOut("stepJump", 14'(t), 14'(volAtten[6:0]));
        else chkOut("stepSize", 14'h1, 14'(volAtten[6:0] - prev));
        if (sel < 2 && seen > 0) chkOut("stepGap", 14'(P * (sel + 1)), 14'(gap));
        seen++;
        gap = 0;
        prev = volAtten[6:0];
      end
    end
    if (n >= 400) begin
      error_cnt++;
      test_done();
    end
    if (sel >= 2) chkOut("stepFast", 14'h1, 14'(n <= 3));
  endtask : stepRun

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  initial begin
    logic [7:0] a;
    logic [6:0] t;
    rstn = 1'b0;
    swReset = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    softStepSel = 2'h2;
    loadShort = 2'h0;
    foreach (mr[i]) mr[i] = REG_RESET;
    repeat (16) @(posedge core_clk);
    #1 rstn = 1'b1;
    outs();
    foreach (ofs[i]) rd(ofs[i]);
    rd(8'h30);
    // random programming, volume jumps straight to target
    for (int k = 0; k < 14; k++) begin
      a = ofs[$unsigned($random(seed)) % 7];
      wr(a, 8'($random(seed)));
      rd(a);
      tick(2);
      outs();
    end
    wr(HP_DRV_CFG_OFS, 8'h06);
    for (int c = 0; c < 4; c++) begin
      wr(HP_PWR_FAULT_OFS, {3'h0, 2'(c), 3'h0});
      tick(2);
      outs();
    end
    wr(SPK_VOL_R_OFS, {1'b0, VOL_MUTE_CODE});
    wr(SPK_VOL_L_OFS, 8'hfe);
    tick(2);
    outs();
    // soft-step every setting, from a low start
    wr(SPK_VOL_L_OFS, 8'h80);
    tick(3);
    t = 7'h0;
    for (int s = 0; s < 4; s++) begin
      t = t + 7'h3 + 7'($unsigned($random(seed)) % 3);
      stepRun(2'(s), t);
    end
    softStepSel = 2'h2;
    // short in current-limit mode, flag not sticky
    wr(HP_PWR_FAULT_OFS, 8'hc0);
    loadShort = 2'h1;
    upd();
    tick(3);
    outs();
    rd(HP_PWR_FAULT_OFS);
    loadShort = 2'h0;
    upd();
    tick(3);
    outs();
    rd(HP_PWR_FAULT_OFS);
    // shutdown mode, right short, three restarts against it, then clear
    wr(HP_PWR_FAULT_OFS, 8'hc2);
    loadShort = 2'h2;
    upd();
    tick(3);
    outs();
    rd(HP_PWR_FAULT_OFS);
    for (int k = 0; k < 3; k++) begin
      wr(HP_PWR_FAULT_OFS, 8'hc2);
      tick(2);
      outs();
      rd(HP_PWR_FAULT_OFS);
    end
    loadShort = 2'h0;
    upd();
    tick(2);
    wr(HP_PWR_FAULT_OFS, 8'hca);
    tick(2);
    outs();
    rd(HP_PWR_FAULT_OFS);
    // master software reset restores everything
    tick(1);
    swReset = 1'b1;
    tick(1);
    swReset = 1'b0;
    foreach (mr[i]) mr[i] = REG_RESET;
    tick(3);
    outs();
    foreach (ofs[i]) rd(ofs[i]);
    test_done();
  end
endmodule : tb

`default_nettype wire

// ===== vol_step_if.sv
// Purpose: carries one channel's soft-step request and applied code
// Assumes: one clock domain
// Notes: ctrl side drives target and timing, stepper returns the code
`default_nettype none

interface vol_step_if;
  logic [6:0] target; // code written by host
  logic stepTick; // one-cycle pulse, step allowed
  logic immediate; // soft-stepping switched off
  logic [6:0] applied; // code the analog stage sees
  modport ctrl (output target, output stepTick, output immediate, input applied);
  modport stepper (input target, input stepTick, input immediate, output applied);
endinterface : vol_step_if

`default_nettype wire

// ===== vol_stepper.sv
// Purpose: soft-steps one channel's applied volume code toward its target
// Assumes: stepTick is a single-cycle pulse
// Notes: immediate mode jumps straight to the target
`default_nettype none

module vol_stepper (
  input wire logic core_clk,
  input wire logic rstn,
  vol_step_if.stepper bus
);
  import volume_ctl_pkg::*;

  logic [6:0] applied_q; // code in effect now

  // one code per tick, never overshoots
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      applied_q <= 7'h00;
    end else if (bus.immediate) begin
      applied_q <= bus.target;
    end else if (bus.stepTick) begin
      if (applied_q < bus.target) begin
        applied_q <= applied_q + 7'h01;
      end else if (applied_q > bus.target) begin
        applied_q <= applied_q - 7'h01;
      end
    end
  end

  assign bus.applied = applied_q;

  // one step toward target per tick
  stepMove_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (bus.stepTick && !bus.immediate && applied_q != bus.target)
    |=> (applied_q == $past(applied_q) + 7'h01 || applied_q == $past(applied_q) - 7'h01))
    else $error("applied code did not move by one step");

  // no movement between ticks
  stepHold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (!bus.stepTick && !bus.immediate) |=> $stable(applied_q))
    else $error("applied code moved without a tick");
endmodule : vol_stepper

`default_nettype wire

// ===== volume_ctl_pkg.sv
// Purpose: shared constants for the output driver volume control block
// Assumes: 25 MHz core clock, page 1 register offsets as byte addresses
// Notes: index 0 of any per-channel vector is left, index 1 is right
// Functional notes
// - codes 117 to 127 give deepest attenuation
// - mute when amp feed off and code 7f
// - two-bit setting picks soft-step interval
// - routing bits 6 and 2 connect dac channels
// - speaker volume codes from registers 38, 39
// - speaker amp fed only when bit 7 set
// - binary 11 in bits 2:1 selects lineout
// - bits 4:3 pick four common-mode levels
// - bits 7 and 6 power headphone drivers
// - gain bits 6:3, mute bit 2 per driver
// - short detection always active, never disabled
// - bit 1 picks current limit or shutdown
// - short disables output, sets read-only bit 0
// - shutdown mode clears the shorted driver power bit
// - restart by master reset or power bit set
// - restarted driver shuts again if short persists
`default_nettype none

package volume_ctl_pkg;
  // register offsets on page 1
  localparam logic [7:0] HP_PWR_FAULT_OFS = 8'h1f;
  localparam logic [7:0] DAC_ROUTE_OFS = 8'h23;
  localparam logic [7:0] SPK_VOL_L_OFS = 8'h26;
  localparam logic [7:0] SPK_VOL_R_OFS = 8'h27;
  localparam logic [7:0] HP_GAIN_L_OFS = 8'h28;
  localparam logic [7:0] HP_GAIN_R_OFS = 8'h29;
  localparam logic [7:0] HP_DRV_CFG_OFS = 8'h2c;
  // headphone power and fault fields
  localparam int HP_PWR_L_POS = 7;
  localparam int HP_PWR_R_POS = 6;
  localparam int HP_CM_LSB = 3;
  localparam int HP_SD_MODE_POS = 1;
  localparam int HP_FAULT_POS = 0;
  // routing fields
  localparam int ROUTE_L_POS = 6;
  localparam int ROUTE_R_POS = 2;
  // speaker volume fields
  localparam int SPK_FEED_POS = 7;
  // headphone gain fields
  localparam int HP_GAIN_LSB = 3;
  localparam int HP_MUTE_POS = 2;
  // drive configuration field
  localparam int DRV_MODE_LSB = 1;
  localparam logic [1:0] DRV_LINEOUT = 2'h3;
  // volume codes
  localparam logic [6:0] VOL_FLOOR_CODE = 7'h75;
  localparam logic [6:0] VOL_MUTE_CODE = 7'h7f;
  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  // soft-step timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int STEP_TIME_NS = 20000;
  localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // soft-step setting codes
  typedef enum logic [1:0] {
    STEP_X1 = 2'h0,
    STEP_X2 = 2'h1,
    STEP_OFF_A = 2'h2,
    STEP_OFF_B = 2'h3
  } step_sel_t;
endpackage : volume_ctl_pkg

`default_nettype wire
